// ==== logic/spi_port_pkg.sv ====
// Constants and types of the serial peripheral slave port.
// Assumes a single system clock; the serial clock is sampled as data.
`default_nettype none
package spi_port_pkg;
	localparam int unsigned CLOCK_HZ          = 100_000_000;
	localparam int unsigned SCLK_MAX_HZ       = 5_000_000;
	// Shortest serial clock phase at the top rate, in system cycles
	localparam int unsigned SCLK_HALF_CYCLES  = CLOCK_HZ / (2 * SCLK_MAX_HZ);
	localparam int unsigned SYNC_LATENCY      = 3;
	localparam logic [2:0]  BYTE_LAST_BIT     = 3'h7;
	localparam logic [2:0]  BOOT_WAIT_CYCLES  = 3'h4;
	localparam logic [2:0]  SLEEP_MODE_PIN    = 3'h1;
	localparam logic [1:0]  API_MODE_SPI      = 2'h1;
	localparam logic [7:0]  SHIFT_RESET       = 8'h00;
	// Pin order: sleep request, strap, data in, select, serial clock
	localparam logic [4:0]  PIN_SYNC_RESET    = 5'h0A;
	localparam int unsigned PIN_SCLK          = 0;
	localparam int unsigned PIN_SSEL_N        = 1;
	localparam int unsigned PIN_MOSI          = 2;
	localparam int unsigned PIN_STRAP         = 3;
	localparam int unsigned PIN_SLEEP_REQ     = 4;

	typedef enum logic [3:0] {
		PORT_BOOT   = 4'h1,
		PORT_UART   = 4'h2,
		PORT_EITHER = 4'h4,
		PORT_SPI    = 4'h8
	} port_e;
endpackage : spi_port_pkg
`default_nettype wire

// ==== logic/pin_sync3.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clock; output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
	parameter int unsigned       WIDTH       = 1,
	parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] filt;
	} sync_s;

	sync_s state;
	sync_s next_state;

	always_comb begin
		next_state      = state;
		next_state.s1   = pin;
		next_state.s2   = state.s1;
		next_state.s3   = state.s2;
		// Stage one feeds stage two only; the filter looks at two and three
		next_state.filt = (~(state.s2 ^ state.s3) & state.s2) | ((state.s2 ^ state.s3) & state.filt);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= '{s1: RESET_VALUE, s2: RESET_VALUE, s3: RESET_VALUE, filt: RESET_VALUE};
		end else begin
			state <= next_state;
		end
	end

	assign level = state.filt;
endmodule : pin_sync3
`default_nettype wire

// ==== logic/msb_shifter.sv ====
// Eight-bit shift register, most significant bit leaves first.
// Assumes load and shift come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module msb_shifter
	import spi_port_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       load,
	input  wire logic [7:0] load_value,
	input  wire logic       shift,
	input  wire logic       shift_in,
	output logic      [7:0] q
);
	typedef struct packed {
		logic [7:0] data;
	} shifter_s;

	shifter_s state;
	shifter_s next_state;

	always_comb begin
		next_state = state;
		if (load) begin
			next_state.data = load_value;
		end else if (shift) begin
			next_state.data = {state.data[6:0], shift_in};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= '{data: SHIFT_RESET};
		end else begin
			state <= next_state;
		end
	end

	assign q = state.data;
endmodule : msb_shifter
`default_nettype wire

// ==== logic/spi_slave_host_port.sv ====
// Serial peripheral slave port of the radio module, facing the host controller.
// Assumes serial clock, select, data in, strap and sleep pins are asynchronous;
// byte stream side (tx_byte, tx_valid, rx_byte) and config bits are on clock.
//
// Functional notes
// - Port is slave only: host supplies clock and data in, we return data out.
// - Attention rises once output is queued, holds until all bytes clocked out.
// - Serial clock up to 5 MHz burst; host never clocks faster, though the bench host model runs at 6.25 MHz.
// - Bytes travel most significant bit first in both directions.
// - Mode 0: clock idles low, data sampled on rising edge.
// - Framing is always API mode 1 without escapes, whatever the setting.
// - Every clocked byte moves both ways; idle output is filler.
// - Output data may start before, with or after input; both run at once.
// - Sleep request pin, when a peripheral, drives pin sleep for both ports.
// - Else with select a peripheral, low select wakes, high select sleeps.
// - Neither pin a peripheral: stay awake in pin sleep mode.
// - Through-hole strap low at reset forces SPI and disables the UART.
// - After forced SPI setup, a modem status frame is queued to SPI.
// - Attention is optional; the port works with it disabled.
// - Forced pin settings revert at reset unless saved.
// - Saved config with UART off and SPI on starts in SPI mode.
// - Both enabled: output to UART until first SPI input, then SPI only.
// - Chosen output port stays until reset.
// - Data out driven only while selected; deselect releases the line.
// - With nothing queued, data out repeats the last bit sent.
`timescale 1ns/100ps
`default_nettype none
module spi_slave_host_port
	import spi_port_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_ssel_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe,
	output logic            attention_out,
	input  wire logic       general_io_line_13,
	input  wire logic       sleep_request_pin,
	input  wire logic       through_hole_part,
	input  wire logic       saved_uart_enable,
	input  wire logic       saved_spi_enable,
	input  wire logic [2:0] sleep_mode_setting,
	input  wire logic       sleep_request_periph,
	input  wire logic       ssel_periph,
	input  wire logic       attention_enable,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_valid,
	output logic            tx_take,
	output logic      [7:0] rx_byte,
	output logic            rx_valid,
	output logic            awake,
	output logic            spi_port_active,
	output logic            uart_enabled,
	output logic            force_spi_pins,
	output logic            status_frame_request,
	output logic      [1:0] api_mode_effective
);
	import spi_port_pkg::*;

	typedef struct packed {
		logic       sclk_prev;
		logic       sel_prev;
		logic [2:0] bit_cnt;
		logic       real_in_flight;
		logic       miso;
		logic       miso_oe;
		logic       attention;
		logic       take;
		logic [7:0] rx_byte;
		logic       rx_valid;
		logic       awake;
		port_e      port;
		logic [2:0] boot_cnt;
		logic       force_pins;
		logic       uart_en;
		logic       status_req;
		logic [1:0] api_mode;
		logic       spi_active;
	} port_s;

	logic [1:0] rst_pipe;
	logic       rst_sync;
	logic [4:0] pins;
	logic [7:0] txq;
	logic [7:0] rxq;
	port_s      state;
	port_s      next_state;
	logic       sclk_f;
	logic       sel;
	logic       rise;
	logic       fall;
	logic       sel_start;
	logic       spi_out;
	logic       tx_load;
	logic       tx_shift;
	logic [7:0] tx_load_value;

	// Reset is released through two flops so all state leaves reset together
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync = rst_pipe[1];

	// Serial clock is oversampled; the filter costs four cycles of a ten-cycle phase
	pin_sync3 #(
		.WIDTH      (5),
		.RESET_VALUE(PIN_SYNC_RESET)
	) u_pins (
		.clock  (clock),
		.reset_n(rst_sync),
		.pin    ({sleep_request_pin, general_io_line_13, spi_mosi, spi_ssel_n, spi_sclk}),
		.level  (pins)
	);

	assign sclk_f    = pins[PIN_SCLK];
	assign sel       = ~pins[PIN_SSEL_N];
	assign rise      = sel & sclk_f & ~state.sclk_prev;
	assign fall      = sel & ~sclk_f & state.sclk_prev;
	assign sel_start = sel & ~state.sel_prev;
	assign spi_out   = (state.port == PORT_SPI);

	// Byte boundary reload; filler is the last bit repeated
	assign tx_load       = sel_start | (fall & (state.bit_cnt == 3'h0));
	assign tx_shift      = fall & (state.bit_cnt != 3'h0);
	assign tx_load_value = (tx_valid & spi_out) ? tx_byte : {8{txq[7]}};

	msb_shifter u_tx (
		.clock     (clock),
		.reset_n   (rst_sync),
		.load      (tx_load),
		.load_value(tx_load_value),
		.shift     (tx_shift),
		.shift_in  (txq[7]),
		.q         (txq)
	);

	msb_shifter u_rx (
		.clock     (clock),
		.reset_n   (rst_sync),
		.load      (sel_start),
		.load_value(SHIFT_RESET),
		.shift     (rise),
		.shift_in  (pins[PIN_MOSI]),
		.q         (rxq)
	);

	always_comb begin
		next_state            = state;
		next_state.sclk_prev  = sclk_f;
		next_state.sel_prev   = sel;
		next_state.take       = 1'b0;
		next_state.rx_valid   = 1'b0;
		next_state.status_req = 1'b0;
		next_state.api_mode   = API_MODE_SPI;

		// Bit counter restarts at every select so a torn byte cannot skew the next
		if (!sel) begin
			next_state.bit_cnt = 3'h0;
		end else if (rise) begin
			next_state.bit_cnt = state.bit_cnt + 3'h1;
		end

		if (rise && state.bit_cnt == BYTE_LAST_BIT) begin
			next_state.rx_byte  = {rxq[6:0], pins[PIN_MOSI]};
			next_state.rx_valid = 1'b1;
		end

		if (tx_load) begin
			next_state.take           = tx_valid & spi_out;
			next_state.real_in_flight = tx_valid & spi_out;
		end

		next_state.miso    = txq[7];
		next_state.miso_oe = sel;
		next_state.attention = attention_enable & spi_out
			& (tx_valid | next_state.real_in_flight);

		unique case (state.port)
			PORT_BOOT: begin
				// Wait for the pin filter to settle before reading the strap
				next_state.boot_cnt = state.boot_cnt + 3'h1;
				if (state.boot_cnt == BOOT_WAIT_CYCLES) begin
					if (through_hole_part && !pins[PIN_STRAP]) begin
						next_state.port       = PORT_SPI;
						next_state.force_pins = 1'b1;
						next_state.uart_en    = 1'b0;
						next_state.status_req = 1'b1;
					end else if (saved_spi_enable && !saved_uart_enable) begin
						next_state.port    = PORT_SPI;
						next_state.uart_en = 1'b0;
					end else if (saved_spi_enable && saved_uart_enable) begin
						next_state.port    = PORT_EITHER;
						next_state.uart_en = 1'b1;
					end else begin
						next_state.port    = PORT_UART;
						next_state.uart_en = 1'b1;
					end
				end
			end
			PORT_EITHER: begin
				if (next_state.rx_valid) begin
					next_state.port    = PORT_SPI;
					next_state.uart_en = 1'b0;
				end
			end
			PORT_UART: begin
				next_state.port = PORT_UART;
			end
			PORT_SPI: begin
				next_state.port = PORT_SPI;
			end
		endcase
		// Registered copy so the port flag leaves a flop, not a decoder
		next_state.spi_active = (next_state.port == PORT_SPI);

		// Sharing select for sleep costs wake time on every deselect
		if (state.port == PORT_BOOT || sleep_mode_setting != SLEEP_MODE_PIN) begin
			next_state.awake = 1'b1;
		end else if (sleep_request_periph) begin
			next_state.awake = ~pins[PIN_SLEEP_REQ];
		end else if (ssel_periph) begin
			next_state.awake = sel;
		end else begin
			next_state.awake = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_sync) begin
		if (!rst_sync) begin
			state <= '{
				sclk_prev:      1'b0,
				sel_prev:       1'b0,
				bit_cnt:        3'h0,
				real_in_flight: 1'b0,
				miso:           1'b0,
				miso_oe:        1'b0,
				attention:      1'b0,
				take:           1'b0,
				rx_byte:        8'h00,
				rx_valid:       1'b0,
				awake:          1'b1,
				port:           PORT_BOOT,
				boot_cnt:       3'h0,
				force_pins:     1'b0,
				uart_en:        1'b0,
				status_req:     1'b0,
				api_mode:       API_MODE_SPI,
				spi_active:     1'b0
			};
		end else begin
			state <= next_state;
		end
	end

	assign spi_miso             = state.miso;
	assign spi_miso_oe          = state.miso_oe;
	assign attention_out        = state.attention;
	assign tx_take              = state.take;
	assign rx_byte              = state.rx_byte;
	assign rx_valid             = state.rx_valid;
	assign awake                = state.awake;
	assign spi_port_active      = state.spi_active;
	assign uart_enabled         = state.uart_en;
	assign force_spi_pins       = state.force_pins;
	assign status_frame_request = state.status_req;
	assign api_mode_effective   = state.api_mode;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_sync);

	sequence s_byte_done;
		rise && state.bit_cnt == BYTE_LAST_BIT;
	endsequence

	sequence s_idle_fall;
		fall && state.bit_cnt == 3'h0 && !(tx_valid && spi_out);
	endsequence

	a_oe_tracks_select: assert property (sel |=> spi_miso_oe)
		else $error("data out not driven while selected");

	a_oe_release: assert property (!sel |=> !spi_miso_oe)
		else $error("data out still driven after deselect");

	a_byte_received: assert property (s_byte_done |=> rx_valid && rx_byte[0] == $past(pins[2]))
		else $error("received byte not delivered at eighth rising edge");

	a_filler_repeats: assert property (s_idle_fall |=> txq == {8{$past(txq[7])}})
		else $error("filler does not repeat the last bit");

	a_attn_queued: assert property (tx_valid && spi_out && attention_enable |=> attention_out)
		else $error("attention missing with output queued");

	a_attn_disabled: assert property (!attention_enable |=> !attention_out)
		else $error("attention driven while disabled");

	a_port_sticky: assert property (spi_out |=> spi_out && !uart_enabled)
		else $error("SPI port selection lost before reset");

	a_api_fixed: assert property (##1 api_mode_effective == API_MODE_SPI)
		else $error("framing mode left API mode 1");

	a_awake_no_periph: assert property (
		state.port != PORT_BOOT && !sleep_request_periph && !ssel_periph |=> awake)
		else $error("device slept with no sleep pin");

	a_select_wakes: assert property (
		state.port != PORT_BOOT && sleep_mode_setting == SLEEP_MODE_PIN
		&& !sleep_request_periph && ssel_periph |=> awake == $past(sel))
		else $error("select does not steer sleep");

	a_forced_status: assert property (
		state.port == PORT_BOOT && next_state.force_pins |=> status_frame_request ##1 !status_frame_request)
		else $error("status frame not requested once after forced SPI");

	a_miso_follows: assert property (tx_shift |=> ##1 spi_miso == $past(txq[6], 2))
		else $error("data out did not advance on falling edge");
endmodule : spi_slave_host_port
`default_nettype wire

// ==== verif/spi_host_model.sv ====
// Behavioural host controller acting as serial master, clock mode 0.
// Assumes clock is the bench clock and miso_line the resolved data line.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input  wire logic clock,
	input  wire logic miso_line,
	output var logic  sclk,
	output var logic  ssel_n,
	output var logic  mosi
);
	initial begin
		sclk   = 1'b0;
		ssel_n = 1'b1;
		mosi   = 1'b0;
	end

	// Eight cycles a phase; clock stands low between frames
	task automatic half;
		repeat (8) @(posedge clock);
	endtask : half

	// Select alone, no clock; steers sleep when select is shared
	task automatic select(input logic on);
		ssel_n <= ~on;
	endtask : select

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		ssel_n <= 1'b0;
		mosi   <= tx[7];
		half();
		half();
		for (int i = 7; i >= 0; i--) begin
			rx[i] = miso_line;
			sclk  <= 1'b1;
			half();
			sclk <= 1'b0;
			if (i > 0) begin
				mosi <= tx[i-1];
			end
			half();
		end
		ssel_n <= 1'b1;
		// Released line must not look like valid data
		mosi <= ~mosi;
		half();
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ==== verif/spi_slave_host_port_tb.sv ====
// Self-checking bench for the serial slave port.
// Assumes the host model drives the serial pins; straps change only in reset.
`timescale 1ns/100ps
`default_nettype none
module spi_slave_host_port_tb;
	import spi_port_pkg::*;
	logic       clock = 1'b0;
	logic       reset_n = 1'b0;
	logic       spi_sclk, spi_ssel_n, spi_mosi, spi_miso, spi_miso_oe, attention_out;
	logic       general_io_line_13 = 1'b1;
	logic       sleep_request_pin = 1'b0;
	logic       through_hole_part = 1'b0;
	logic       saved_uart_enable = 1'b1;
	logic       saved_spi_enable = 1'b0;
	logic [2:0] sleep_mode_setting = 3'h0;
	logic       sleep_request_periph = 1'b0;
	logic       ssel_periph = 1'b0;
	logic       attention_enable = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic       tx_valid = 1'b0;
	logic       tx_take, rx_valid, awake, spi_port_active, uart_enabled;
	logic       force_spi_pins, status_frame_request;
	logic [7:0] rx_byte;
	logic [7:0] rx_seen = 8'h00;
	logic [1:0] api_mode_effective;
	logic       miso_last = 1'b0;
	logic       miso_line;
	int         n_status = 0;
	int         n_mismatch = 0;
	int         tests_run = 0;

	always #5 clock = ~clock;

	spi_slave_host_port DUT (.clock, .reset_n, .spi_sclk, .spi_ssel_n, .spi_mosi,
		.spi_miso, .spi_miso_oe, .attention_out, .general_io_line_13,
		.sleep_request_pin, .through_hole_part, .saved_uart_enable, .saved_spi_enable,
		.sleep_mode_setting, .sleep_request_periph, .ssel_periph, .attention_enable,
		.tx_byte, .tx_valid, .tx_take, .rx_byte, .rx_valid, .awake, .spi_port_active,
		.uart_enabled, .force_spi_pins, .status_frame_request, .api_mode_effective);

	spi_host_model host (.clock(clock), .miso_line(miso_line), .sclk(spi_sclk),
		.ssel_n(spi_ssel_n), .mosi(spi_mosi));

	// Undriven line shows the inverse, never a stale valid bit
	assign miso_line = (spi_miso_oe === 1'b1) ? spi_miso : ~miso_last;

	always @(posedge clock) begin
		if (spi_miso_oe === 1'b1) miso_last <= spi_miso;
		if (rx_valid === 1'b1) rx_seen <= rx_byte;
		if (tx_take === 1'b1) tx_valid <= 1'b0;
		if (reset_n === 1'b0) n_status <= 0;
		else if (status_frame_request === 1'b1) n_status <= n_status + 1;
	end

	task automatic chk_bit(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask : chk_bit

	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk_byte

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	task automatic boot(input logic [3:0] c);
		reset_n <= 1'b0;
		{through_hole_part, general_io_line_13, saved_uart_enable, saved_spi_enable} <= c;
		tx_valid <= 1'b0;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		repeat (24) @(posedge clock);
	endtask : boot

	task automatic queue(input logic [7:0] b);
		@(posedge clock);
		tx_byte  <= b;
		tx_valid <= 1'b1;
	endtask : queue

	task automatic wait8;
		repeat (8) @(posedge clock);
	endtask : wait8

	// Expected: spi active, forced pins, uart on, one status pulse
	task automatic test_port;
		logic [3:0] cfg [4] = '{4'b1000, 4'b0001, 4'b0111, 4'b0110};
		logic [3:0] exp [4] = '{4'b1101, 4'b1000, 4'b0010, 4'b0010};
		for (int k = 0; k < 4; k++) begin
			boot(cfg[k]);
			chk_byte("port", {4'h0, exp[k]}, {4'h0, spi_port_active, force_spi_pins,
				uart_enabled, n_status == 1});
			chk_byte("api", {6'h00, API_MODE_SPI}, {6'h00, api_mode_effective});
		end
		$display("test port done");
	endtask : test_port

	task automatic test_duplex;
		logic [7:0] got;
		boot(4'b1000);
		attention_enable <= 1'b1;
		queue(8'h5A);
		repeat (4) @(posedge clock);
		chk_bit("attention", 1'b1, attention_out);
		host.xfer(8'h3C, got);
		chk_byte("miso", 8'h5A, got);
		chk_byte("rx", 8'h3C, rx_seen);
		chk_bit("taken", 1'b0, tx_valid);
		queue(8'hA5);
		host.xfer(8'hC3, got);
		chk_byte("miso", 8'hA5, got);
		chk_byte("rx", 8'hC3, rx_seen);
		wait8();
		chk_bit("attention", 1'b0, attention_out);
		chk_bit("oe", 1'b0, spi_miso_oe);
		host.xfer(8'h96, got);
		// Uniform filler lets the host drop it as outside any frame
		chk_byte("filler", 8'hFF, got);
		chk_byte("rx", 8'h96, rx_seen);
		attention_enable <= 1'b0;
		queue(8'hC3);
		repeat (4) @(posedge clock);
		chk_bit("attention", 1'b0, attention_out);
		host.xfer(8'h00, got);
		chk_byte("miso", 8'hC3, got);
		$display("test duplex done");
	endtask : test_duplex

	task automatic test_either;
		logic [7:0] got;
		boot(4'b0111);
		attention_enable <= 1'b1;
		queue(8'h81);
		repeat (16) @(posedge clock);
		chk_bit("spi", 1'b0, spi_port_active);
		chk_bit("queued", 1'b1, tx_valid);
		host.xfer(8'h7E, got);
		// Byte still owed to the UART during the first SPI input
		chk_byte("filler", 8'h00, got);
		chk_bit("moved", 1'b0, tx_valid);
		// Live config change must not move the port
		saved_spi_enable <= 1'b0;
		repeat (16) @(posedge clock);
		chk_bit("spi", 1'b1, spi_port_active);
		chk_bit("uart", 1'b0, uart_enabled);
		tx_valid <= 1'b0;
		$display("test either done");
	endtask : test_either

	task automatic test_sleep;
		sleep_mode_setting   <= SLEEP_MODE_PIN;
		sleep_request_periph <= 1'b1;
		sleep_request_pin    <= 1'b1;
		wait8();
		chk_bit("awake", 1'b0, awake);
		sleep_request_pin <= 1'b0;
		wait8();
		chk_bit("awake", 1'b1, awake);
		sleep_request_periph <= 1'b0;
		ssel_periph          <= 1'b1;
		wait8();
		chk_bit("awake", 1'b0, awake);
		host.select(1'b1);
		wait8();
		chk_bit("awake", 1'b1, awake);
		host.select(1'b0);
		ssel_periph <= 1'b0;
		wait8();
		chk_bit("awake", 1'b1, awake);
		$display("test sleep done");
	endtask : test_sleep

	initial begin
		test_port();
		test_duplex();
		test_either();
		test_sleep();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		close_out();
	end
endmodule : spi_slave_host_port_tb
`default_nettype wire
